// File: hdl/bbwm_core.sv
/*
 * Write port of a four-word burst SRAM with per-lane write masking.
 * Assumes the memory input clocks and all write-side pins are asynchronous
 * to sys_clk_in, which runs several times faster than the input clocks.
 */
`timescale 1ns/1ns
module bbwm_core #(
    parameter int WIDTH  = bbwm_pkg::DEF_WIDTH,
    parameter int ADDR_W = bbwm_pkg::DEF_ADDR_W
) (
    input  wire logic                                sys_clk_in,
    input  wire logic                                rst_in,
    input  wire logic                                mem_clk_in,
    input  wire logic                                mem_clk_n_in,
    input  wire logic                                read_port_select_n_in,
    input  wire logic                                write_port_select_n_in,
    input  wire logic [ADDR_W-1:0]                   addr_in,
    input  wire logic [WIDTH-1:0]                    wr_data_in,
    input  wire logic [WIDTH/bbwm_pkg::LANE_W-1:0]   lane_write_sel_n_in,
    input  wire logic [ADDR_W-1:0]                   peek_addr_in,
    output logic      [WIDTH-1:0]                    peek_data_out,
    output logic                                     rd_data_oe_out,
    output logic                                     rd_start_out,
    output logic                                     wr_start_out,
    output logic                                     wr_commit_out
);
    import bbwm_pkg::*;

    localparam int LANES = WIDTH / LANE_W;
    localparam int PIN_W = 4 + ADDR_W + WIDTH + LANES;
    localparam int DEPTH = 1 << ADDR_W;

    // Refuses widths other than two or four lanes and arrays too small for a burst.
    if (!(WIDTH == 2 * LANE_W || WIDTH == 4 * LANE_W) || ADDR_W < 2) begin : g_bad_param
        $error("bbwm_core: unsupported WIDTH or ADDR_W");
    end

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    // Keeps each lane whose select is high and replaces each low one.
    function automatic logic [WIDTH-1:0] lane_merge(input logic [WIDTH-1:0] old_w,
                                                    input logic [WIDTH-1:0] new_w,
                                                    input logic [LANES-1:0] sel_n);
        logic [WIDTH-1:0] res;
        res = old_w;
        for (int l = 0; l < LANES; l++) begin
            if (!sel_n[l]) begin
                res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

    function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                     input int idx);
        return base + ADDR_W'(idx);
    endfunction

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [PIN_W-1:0] pin_s0_r;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic             k_lvl_r;
    logic             kn_lvl_r;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s0_r <= '1;
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s0_r <= {read_port_select_n_in, write_port_select_n_in, lane_write_sel_n_in,
                         addr_in, wr_data_in, mem_clk_n_in, mem_clk_in};
            pin_s1_r <= pin_s0_r;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire             k_agree   = (pin_s1_r[0] == pin_s2_r[0]);
    wire             kn_agree  = (pin_s1_r[1] == pin_s2_r[1]);
    wire             k_rise    = k_agree && pin_s2_r[0] && !k_lvl_r;
    wire             kn_rise   = kn_agree && pin_s2_r[1] && !kn_lvl_r;
    wire [WIDTH-1:0] smp_data  = pin_s2_r[2 +: WIDTH];
    wire [ADDR_W-1:0] smp_addr = pin_s2_r[2+WIDTH +: ADDR_W];
    wire [LANES-1:0] smp_sel_n = pin_s2_r[2+WIDTH+ADDR_W +: LANES];
    wire             smp_wps_n = pin_s2_r[PIN_W-2];
    wire             smp_rps_n = pin_s2_r[PIN_W-1];

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            k_lvl_r  <= 1'b1;
            kn_lvl_r <= 1'b1;
        end else begin
            k_lvl_r  <= k_agree ? pin_s2_r[0] : k_lvl_r;
            kn_lvl_r <= kn_agree ? pin_s2_r[1] : kn_lvl_r;
        end
    end

    // ---------------------------------------------------------------
    // Initiation and arbitration
    // ---------------------------------------------------------------
    logic rd_prev_r;
    logic wr_prev_r;

    wire rd_go = k_rise && !smp_rps_n && !rd_prev_r;
    wire wr_go = k_rise && !smp_wps_n && !wr_prev_r && !rd_go;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end else if (k_rise) begin
            rd_prev_r <= rd_go;
            wr_prev_r <= wr_go;
        end
    end

    // ---------------------------------------------------------------
    // Burst capture
    // ---------------------------------------------------------------
    bbwm_cap_t         cap_r;
    bbwm_cap_t         cap_nxt;
    logic              pend_r;
    logic [ADDR_W-1:0] pend_addr_r;
    logic [ADDR_W-1:0] base_r;
    logic [WIDTH-1:0]  buf_r [BURST_LEN];
    logic [LANES-1:0]  mask_r [BURST_LEN];
    logic              commit_r;

    // word order K, K#, K, K#
    always_comb begin
        cap_nxt = cap_r;
        case (cap_r)
            CAP_W0: if (k_rise && pend_r) cap_nxt = CAP_W1;
            CAP_W1: if (kn_rise) cap_nxt = CAP_W2;
            CAP_W2: if (k_rise) cap_nxt = CAP_W3;
            CAP_W3: if (kn_rise) cap_nxt = CAP_W0;
            default: cap_nxt = CAP_W0;
        endcase
    end

    wire       cap_take = (cap_nxt != cap_r);
    wire [1:0] cap_idx  = cap_r;
    wire       cap_last = cap_take && (cap_r == CAP_W3);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cap_r       <= CAP_W0;
            pend_r      <= 1'b0;
            pend_addr_r <= '0;
            base_r      <= '0;
        end else begin
            cap_r <= cap_nxt;
            if (wr_go) begin
                pend_r      <= 1'b1;
                pend_addr_r <= smp_addr;
            end else if (cap_take && cap_r == CAP_W0) begin
                pend_r <= 1'b0;
            end
            if (cap_take && cap_r == CAP_W0) begin
                base_r <= pend_addr_r;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (cap_take) begin
            buf_r[cap_idx]  <= smp_data;
            mask_r[cap_idx] <= smp_sel_n;
        end
    end

    // ---------------------------------------------------------------
    // Array commit
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            commit_r <= 1'b0;
        end else begin
            commit_r <= cap_last;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (commit_r) begin
            for (int i = 0; i < BURST_LEN; i++) begin
                mem[burst_addr(base_r, i)] <= lane_merge(mem[burst_addr(base_r, i)],
                                                         buf_r[i], mask_r[i]);
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            peek_data_out  <= '0;
            rd_data_oe_out <= 1'b0;
            rd_start_out   <= 1'b0;
            wr_start_out   <= 1'b0;
            wr_commit_out  <= 1'b0;
        end else begin
            peek_data_out  <= mem[peek_addr_in];
            rd_data_oe_out <= 1'b0;
            rd_start_out   <= rd_go;
            wr_start_out   <= wr_go;
            wr_commit_out  <= cap_last;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // Tracks whether a K rise has passed since the last accepted write.
    logic wr_gap_r;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_gap_r <= 1'b1;
        end else if (wr_go) begin
            wr_gap_r <= 1'b0;
        end else if (k_rise) begin
            wr_gap_r <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    commit_timing_a: assert property (cap_last |=> commit_r && wr_commit_out)
        else $error("burst commit not one cycle after last word");
    full_write_a: assert property (commit_r && mask_r[0] == '0
        |=> mem[$past(base_r)] == $past(buf_r[0]))
        else $error("all-low selects did not write the whole word");
    lane_keep_a: assert property (commit_r && mask_r[1] == '1
        |=> $stable(mem[burst_addr(base_r, 1)]))
        else $error("all-high selects altered stored word");
    lane_merge_a: assert property (commit_r
        |=> mem[$past(burst_addr(base_r, 2))][LANE_W-1:0]
            == ($past(mask_r[2][0])
                ? $past(mem[burst_addr(base_r, 2)][LANE_W-1:0])
                : $past(buf_r[2][LANE_W-1:0])))
        else $error("lane merge wrong in low lane of third word");
    lane_top_a: assert property (commit_r
        |=> mem[$past(burst_addr(base_r, 2))][WIDTH-1 -: LANE_W]
            == ($past(mask_r[2][LANES-1])
                ? $past(mem[burst_addr(base_r, 2)][WIDTH-1 -: LANE_W])
                : $past(buf_r[2][WIDTH-1 -: LANE_W])))
        else $error("lane merge wrong in top lane of third word");
    addr_seq_a: assert property (commit_r && mask_r[3] == '0
        |=> mem[$past(base_r) + ADDR_W'(3)] == $past(buf_r[3]))
        else $error("last word not at base plus three");
    no_repeat_a: assert property (wr_go |-> wr_gap_r)
        else $error("write initiated on consecutive positive rises");
    dont_care_a: assert property (k_rise && wr_prev_r && !smp_wps_n |-> !wr_go)
        else $error("repeated write select was not ignored");
    hiz_out_a: assert property (!rd_data_oe_out)
        else $error("read data driven by write-port block");
    mask_sample_a: assert property (cap_take |=> mask_r[$past(cap_idx)] == $past(smp_sel_n))
        else $error("lane selects not sampled with the word");
    word_order_a: assert property (cap_r == CAP_W1 && kn_rise |=> cap_r == CAP_W2)
        else $error("second word not taken on negative clock rise");

    full_burst_c: cover property (commit_r && mask_r[0] == '0);
    partial_c: cover property (commit_r && mask_r[1] != '0 && mask_r[1] != '1);
    pipelined_c: cover property (wr_go && cap_r != CAP_W0);
    both_sel_c: cover property (k_rise && !smp_rps_n && !smp_wps_n);

endmodule // bbwm_core

// File: hdl/bbwm_pkg.sv
/*
 * Constants for the burst byte write mask block of a separate-I/O burst SRAM.
 * Assumes a single system clock that oversamples the memory input clocks.
 */
package bbwm_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int LANE_W      = 9;
    localparam int BURST_LEN   = 4;
    localparam int DEF_WIDTH   = 18;
    localparam int DEF_ADDR_W  = 20;
    localparam int SYNC_STAGES = 3;

    // ---------------------------------------------------------------
    // Burst capture states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CAP_W0,
        CAP_W1,
        CAP_W2,
        CAP_W3
    } bbwm_cap_t;

endpackage

// File: testbench/bbwm_ctrl_model.sv
/*
 * Memory controller model that drives four-word write bursts on the write pins.
 * Assumes sys_clk_in is the bench clock; pins move only just after its edges.
 */
`timescale 1ns/1ns
module bbwm_ctrl_model (
    input  wire logic        sys_clk_in,
    output logic             mem_clk_out,
    output logic             mem_clk_n_out,
    output logic             rsel_n_out,
    output logic             wsel_n_out,
    output logic [5:0]       addr_out,
    output logic [35:0]      data_out,
    output logic [3:0]       lanes_n_out
);
    initial {mem_clk_out, mem_clk_n_out, rsel_n_out, wsel_n_out, addr_out, data_out,
             lanes_n_out} = '1;

    // ----------------------------------------------------------------
    // One half period: pins change mid-way, clocks change at its end.
    // ----------------------------------------------------------------
    task automatic slot(input logic [1:0] s, input logic [5:0] a, input logic [35:0] d,
                        input logic [3:0] m, input logic [1:0] kk);
        repeat (5) @(posedge sys_clk_in);
        {rsel_n_out, wsel_n_out, addr_out, data_out, lanes_n_out} <= {s, a, d, m};
        repeat (5) @(posedge sys_clk_in);
        {mem_clk_out, mem_clk_n_out} <= kk;
    endtask

    task automatic burst(input logic [5:0] a, input logic [3:0][35:0] d,
                         input logic [3:0][3:0] m, input logic dbl, input logic rd);
        slot(2'b11, a, ~data_out, 4'hf, 2'b01);
        slot(2'b10, a, ~data_out, 4'hf, 2'b10);
        slot(2'b11, ~a, ~data_out, 4'hf, 2'b01);
        for (int i = 0; i < 4; i++) begin
            slot({1'b1, (i != 0 || !dbl)}, ~a, d[i], m[i], i[0] ? 2'b01 : 2'b10);
        end
        slot(rd ? 2'b00 : 2'b11, ~a, ~data_out, 4'hf, 2'b11);
    endtask
endmodule // bbwm_ctrl_model

// File: testbench/bbwm_core_bench.sv
/*
 * Bench for the burst write mask: a wide and a narrow core share one controller.
 * Assumes the narrow core's array equals the two low lanes of the wide one.
 */
`timescale 1ns/1ns
module bbwm_core_bench;
    import bbwm_pkg::*;
    logic        sys_clk_in, rst_in, k, kn, ws, read_port_select, pv;
    logic        pv_q = 1'b0;
    logic        rd_any = 1'b0;
    logic [1:0]  oe, rs, wst, wc;
    logic [5:0]  a, pa;
    logic [35:0] d, pw, e;
    logic [35:0] sh [64];
    logic [35:0] q [$];
    logic [17:0] pn;
    logic [3:0]  m;
    logic [3:0][3:0] mm;
    logic [1:0][15:0] tab = {16'h3cf7, 16'hbde0};
    int          n_errors, check_count, n_start, n_commit, nb, n_rd, nr;
    int          seed = 38;

    bbwm_ctrl_model u_bbwm_ctrl_model (.sys_clk_in(sys_clk_in), .mem_clk_out(k),
        .mem_clk_n_out(kn), .rsel_n_out(read_port_select), .wsel_n_out(ws), .addr_out(a), .data_out(d),
        .lanes_n_out(m));
    bbwm_core #(.WIDTH(36), .ADDR_W(6)) u_bbwm_core (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .mem_clk_in(k), .mem_clk_n_in(kn), .read_port_select_n_in(read_port_select),
        .write_port_select_n_in(ws), .addr_in(a), .wr_data_in(d), .lane_write_sel_n_in(m),
        .peek_addr_in(pa), .peek_data_out(pw), .rd_data_oe_out(oe[0]),
        .rd_start_out(rs[0]), .wr_start_out(wst[0]), .wr_commit_out(wc[0]));
    bbwm_core #(.WIDTH(18), .ADDR_W(6)) u_bbwm_core_18 (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .mem_clk_in(k), .mem_clk_n_in(kn), .read_port_select_n_in(read_port_select),
        .write_port_select_n_in(ws), .addr_in(a), .wr_data_in(d[17:0]),
        .lane_write_sel_n_in(m[1:0]), .peek_addr_in(pa), .peek_data_out(pn),
        .rd_data_oe_out(oe[1]), .rd_start_out(rs[1]), .wr_start_out(wst[1]),
        .wr_commit_out(wc[1]));

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // ----------------------------------------------------------------
    // Checking and closing.
    // ----------------------------------------------------------------
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp_v);
        check_count++;
        if (seen !== exp_v) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp_v);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        pv_q <= pv;
        if (!rst_in) begin
            n_start <= n_start + int'(wst[0]) + int'(wst[1]);
            n_commit <= n_commit + int'(wc[0]) + int'(wc[1]);
            n_rd <= n_rd + int'(rs[0]) + int'(rs[1]);
            rd_any <= rd_any | (|oe);
        end
        if (pv_q) begin
            e = q.pop_front();
            chk(pw, e);
            chk({18'h0, pn}, {18'h0, e[17:0]});
        end
    end

    // ----------------------------------------------------------------
    // Stimulus: one burst, then peek its four locations.
    // ----------------------------------------------------------------
    task automatic run(input logic [5:0] b, input logic [3:0][3:0] mk, input logic dbl,
                       input logic rd);
        logic [3:0][35:0] dd;
        logic [5:0]       ad;
        for (int i = 0; i < 4; i++) begin
            dd[i] = {4'($random(seed)), 32'($random(seed))};
        end
        nb++;
        nr += int'(rd);
        u_bbwm_ctrl_model.burst(b, dd, mk, dbl, rd);
        for (int i = 0; i < 200 && n_commit != 2 * nb; i++) begin
            @(posedge sys_clk_in);
        end
        if (n_commit != 2 * nb) begin
            n_errors++;
            finish_test();
        end
        for (int i = 0; i < 4; i++) begin
            ad = b + 6'(i);
            for (int l = 0; l < 4; l++) begin
                if (!mk[i][l]) sh[ad][9*l +: 9] = dd[i][9*l +: 9];
            end
            @(posedge sys_clk_in);
            pa <= ad;
            pv <= 1'b1;
            q.push_back(sh[ad]);
        end
        @(posedge sys_clk_in);
        pv <= 1'b0;
    endtask

    initial begin
        rst_in = 1'b1;
        pv = 1'b0;
        pa = '0;
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        for (int j = 0; j < 16; j++) begin
            run(6'(4 * j), 16'h0, 1'b0, 1'b0);
        end
        for (int j = 0; j < 12; j++) begin
            mm = j < 2 ? tab[j] : 16'($random(seed));
            run(j == 0 ? 6'h3e : 6'($random(seed)), mm, j == 5, j == 7 || j == 9);
        end
        chk(36'(n_start), 36'(2 * nb));
        chk(36'(n_rd), 36'(2 * nr));
        chk(36'(rd_any), 36'h0);
        finish_test();
    end
endmodule // bbwm_core_bench
